// ### design/shs_pkg.sv
// Purpose: shared types and constants of the switch based homing sequencer
// Assumes: one system clock, switch levels high when the switch is active
// Notes:   methods 17 to 25 only; no index pulse anywhere
package shs_pkg;

	localparam int unsigned SPD_W  = 16;
	localparam int unsigned POS_W  = 32;
	localparam int unsigned METH_W = 6;

	localparam logic [METH_W-1:0] METH_NEG_LIM  = 6'h11;
	localparam logic [METH_W-1:0] METH_POS_LIM  = 6'h12;
	localparam logic [METH_W-1:0] METH_HOME_A   = 6'h13;
	localparam logic [METH_W-1:0] METH_HOME_B   = 6'h14;
	localparam logic [METH_W-1:0] METH_HOME_C   = 6'h15;
	localparam logic [METH_W-1:0] METH_HOME_D   = 6'h16;
	localparam logic [METH_W-1:0] METH_PLIM_A   = 6'h17;
	localparam logic [METH_W-1:0] METH_PLIM_B   = 6'h18;
	localparam logic [METH_W-1:0] METH_PLIM_C   = 6'h19;

	localparam logic [1:0] STEP_0 = 2'h0;
	localparam logic [1:0] STEP_1 = 2'h1;
	localparam logic [1:0] STEP_2 = 2'h2;

	// Switch levels, at the pins and after synchronising
	typedef struct packed {
		logic neg;
		logic pos;
		logic home;
	} shs_sw_t;

	// Which switch a segment watches
	typedef enum logic [1:0] {
		WATCH_NEG  = 2'h0,
		WATCH_POS  = 2'h1,
		WATCH_HOME = 2'h2
	} shs_watch_t;

	// One motion segment and the level that ends it
	typedef struct packed {
		logic       fwd;
		logic       spd2;
		shs_watch_t watch;
		logic       lvl;
		logic       last;
	} shs_seg_t;

	// Command to the axis
	typedef struct packed {
		logic             run;
		logic             fwd;
		logic [SPD_W-1:0] speed;
	} shs_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SEG0 = 3'h1,
		ST_SEG1 = 3'h3,
		ST_SEG2 = 3'h2,
		ST_DONE = 3'h6
	} shs_state_t;

endpackage

// ### design/shs_homing.sv
// Purpose: homing sequencer for one axis, methods 17 to 25, switch edges only
// Assumes: trig_i, method_i, speeds and pos_i come from logic on clk_i
// Notes:   switch pins pass a three stage synchroniser before use
// How it works
// - Method 17, neg low: reverse, then forward
// - Method 17, neg high: forward slow, latch
// - Method 18, pos low: forward, then reverse
// - Method 18, pos high: reverse slow, latch
// - Method 19, home low: forward, reverse, latch
// - Method 19, home high: reverse, latch low
// - Method 20: latch on home rising
// - Method 21: reverse search when home low, forward slow when high, latch home falling
// - Method 22: latch on home rising
// - Method 23, home low: forward, reverse, latch
// - Method 23, home high: reverse, latch low
// - Methods 23-25: positive limit reverses search
// - Method 24, home low: latch home rising
// - Method 24, home high: reverse, forward, latch
// - Method 24 after limit: out at first speed, back slow, latch
// - Method 25, home low: three segments, latch
// - Method 25, home high: forward, reverse, latch
// - Method 25 after limit: latch home rising
// - Home from switches only, no index
`timescale 1ns/10ps

module shs_homing (
	input  wire logic                          clk_i,
	input  wire logic                          nrst_i,
	input  wire logic                          trig_i,
	input  wire logic [shs_pkg::METH_W-1:0]    method_i,
	input  wire logic [shs_pkg::SPD_W-1:0]     speed1_i,
	input  wire logic [shs_pkg::SPD_W-1:0]     speed2_i,
	input  wire logic [shs_pkg::POS_W-1:0]     pos_i,
	input  wire shs_pkg::shs_sw_t              sw_pin_i,
	output shs_pkg::shs_cmd_t                  cmd_o,
	output logic      [shs_pkg::POS_W-1:0]     home_pos_o,
	output logic                               done_o,
	output logic                               busy_o,
	output logic                               err_o
);

	function automatic shs_pkg::shs_seg_t mk(input logic fwd, input logic spd2,
		input shs_pkg::shs_watch_t watch, input logic lvl, input logic last);
		shs_pkg::shs_seg_t s;
		s.fwd   = fwd;
		s.spd2  = spd2;
		s.watch = watch;
		s.lvl   = lvl;
		s.last  = last;
		return s;
	endfunction

	// Segment table: method, level at trigger, limit path, step
	function automatic shs_pkg::shs_seg_t seg_of(input logic [shs_pkg::METH_W-1:0] m,
		input logic hi, input logic lim, input logic [1:0] st);
		shs_pkg::shs_seg_t s;
		s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b0, 1'b1);
		unique case (m)
			shs_pkg::METH_NEG_LIM: begin
				if (hi || st == shs_pkg::STEP_1)
					s = mk(1'b1, 1'b1, shs_pkg::WATCH_NEG, 1'b0, 1'b1);
				else
					s = mk(1'b0, 1'b0, shs_pkg::WATCH_NEG, 1'b1, 1'b0);
			end
			shs_pkg::METH_POS_LIM: begin
				if (hi || st == shs_pkg::STEP_1)
					s = mk(1'b0, 1'b1, shs_pkg::WATCH_POS, 1'b0, 1'b1);
				else
					s = mk(1'b1, 1'b0, shs_pkg::WATCH_POS, 1'b1, 1'b0);
			end
			shs_pkg::METH_HOME_A, shs_pkg::METH_PLIM_A: begin
				if (hi || st == shs_pkg::STEP_1)
					s = mk(1'b0, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b1);
				else if (lim)
					s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b0);
				else
					s = mk(1'b1, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b0);
			end
			shs_pkg::METH_HOME_B: begin
				if (hi && st == shs_pkg::STEP_0)
					s = mk(1'b0, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b0);
				else
					s = mk(1'b1, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
			end
			shs_pkg::METH_HOME_C: begin
				if (hi || st == shs_pkg::STEP_1)
					s = mk(1'b1, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b1);
				else
					s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b0);
			end
			shs_pkg::METH_HOME_D: begin
				if (hi && st == shs_pkg::STEP_0)
					s = mk(1'b1, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b0);
				else
					s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
			end
			shs_pkg::METH_PLIM_B: begin
				// out of the switch at first speed after limit, back in slow
				if (lim) begin
					if (st == shs_pkg::STEP_0)
						s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b0);
					else if (st == shs_pkg::STEP_1)
						s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b0, 1'b0);
					else
						s = mk(1'b1, 1'b1, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
				end else if (hi) begin
					if (st == shs_pkg::STEP_0)
						s = mk(1'b0, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b0);
					else
						s = mk(1'b1, 1'b1, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
				end else begin
					s = mk(1'b1, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
				end
			end
			shs_pkg::METH_PLIM_C: begin
				// limit path latches on rising home
				if (lim)
					s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
				else if (!hi && st == shs_pkg::STEP_0)
					s = mk(1'b1, 1'b0, shs_pkg::WATCH_HOME, 1'b1, 1'b0);
				else if ((hi && st == shs_pkg::STEP_0) || (!hi && st == shs_pkg::STEP_1))
					s = mk(1'b1, 1'b1, shs_pkg::WATCH_HOME, 1'b0, 1'b0);
				else
					s = mk(1'b0, 1'b1, shs_pkg::WATCH_HOME, 1'b1, 1'b1);
			end
			default: s = mk(1'b0, 1'b0, shs_pkg::WATCH_HOME, 1'b0, 1'b1);
		endcase
		return s;
	endfunction

	function automatic logic [1:0] step_of(input shs_pkg::shs_state_t st);
		unique case (st)
			shs_pkg::ST_SEG1: return shs_pkg::STEP_1;
			shs_pkg::ST_SEG2: return shs_pkg::STEP_2;
			default:          return shs_pkg::STEP_0;
		endcase
	endfunction

	function automatic logic sw_sel(input shs_pkg::shs_sw_t sw, input shs_pkg::shs_watch_t w);
		unique case (w)
			shs_pkg::WATCH_NEG: return sw.neg;
			shs_pkg::WATCH_POS: return sw.pos;
			default:            return sw.home;
		endcase
	endfunction

	function automatic logic meth_ok(input logic [shs_pkg::METH_W-1:0] m);
		return (m >= shs_pkg::METH_NEG_LIM) && (m <= shs_pkg::METH_PLIM_C);
	endfunction

	// three stage synchroniser, level taken once stages two and three agree
	shs_pkg::shs_sw_t sync1_q, sync2_q, sync3_q, sw_q, sw_d;

	always_comb begin
		sw_d = sw_q;
		if (sync2_q == sync3_q)
			sw_d = sync3_q;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			sw_q    <= '0;
		end else begin
			sync1_q <= sw_pin_i;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			sw_q    <= sw_d;
		end
	end

	shs_pkg::shs_state_t          state_q, state_d;
	logic [shs_pkg::METH_W-1:0]   meth_q, meth_d;
	logic                         hi_q, hi_d;
	logic                         lim_q, lim_d;
	shs_pkg::shs_cmd_t            cmd_q, cmd_d;
	logic [shs_pkg::POS_W-1:0]    home_q, home_d;
	logic                         done_q, done_d;
	logic                         err_q, err_d;
	logic                         accept;
	logic                         moving;
	shs_pkg::shs_seg_t            cur, nxt;

	assign accept = trig_i && (state_q == shs_pkg::ST_IDLE || state_q == shs_pkg::ST_DONE);
	assign moving = (state_q == shs_pkg::ST_SEG0) || (state_q == shs_pkg::ST_SEG1)
		|| (state_q == shs_pkg::ST_SEG2);
	assign cur    = seg_of(meth_q, hi_q, lim_q, step_of(state_q));

	always_comb begin
		state_d = state_q;
		meth_d  = meth_q;
		hi_d    = hi_q;
		lim_d   = lim_q;
		home_d  = home_q;
		done_d  = done_q;
		err_d   = err_q;
		unique case (state_q)
			shs_pkg::ST_IDLE, shs_pkg::ST_DONE: begin
				// Trigger while moving is ignored so a run cannot be cut short
				if (accept) begin
					done_d = 1'b0;
					lim_d  = 1'b0;
					meth_d = method_i;
					err_d  = !meth_ok(method_i);
					if (meth_ok(method_i)) begin
						state_d = shs_pkg::ST_SEG0;
						if (method_i == shs_pkg::METH_NEG_LIM)
							hi_d = sw_q.neg;
						else if (method_i == shs_pkg::METH_POS_LIM)
							hi_d = sw_q.pos;
						else
							hi_d = sw_q.home;
					end else begin
						state_d = shs_pkg::ST_IDLE;
					end
				end
			end
			shs_pkg::ST_SEG0, shs_pkg::ST_SEG1, shs_pkg::ST_SEG2: begin
				// limit hit during the first forward search
				if (meth_q >= shs_pkg::METH_PLIM_A && !lim_q && !hi_q
					&& state_q == shs_pkg::ST_SEG0 && sw_q.pos && !sw_q.home) begin
					lim_d = 1'b1;
				// only switch levels end a segment
				end else if (sw_sel(sw_q, cur.watch) == cur.lvl) begin
					if (cur.last) begin
						state_d = shs_pkg::ST_DONE;
						home_d  = pos_i;
						done_d  = 1'b1;
					end else if (state_q == shs_pkg::ST_SEG0) begin
						state_d = shs_pkg::ST_SEG1;
					end else begin
						state_d = shs_pkg::ST_SEG2;
					end
				end
			end
			default: state_d = shs_pkg::ST_IDLE;
		endcase
	end

	// speed taken from the configured value of the segment
	always_comb begin
		nxt         = seg_of(meth_d, hi_d, lim_d, step_of(state_d));
		cmd_d.run   = (state_d == shs_pkg::ST_SEG0) || (state_d == shs_pkg::ST_SEG1)
			|| (state_d == shs_pkg::ST_SEG2);
		cmd_d.fwd   = cmd_d.run && nxt.fwd;
		cmd_d.speed = '0;
		if (cmd_d.run)
			cmd_d.speed = nxt.spd2 ? speed2_i : speed1_i;
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= shs_pkg::ST_IDLE;
			meth_q  <= '0;
			hi_q    <= 1'b0;
			lim_q   <= 1'b0;
			cmd_q   <= '0;
			home_q  <= '0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			meth_q  <= meth_d;
			hi_q    <= hi_d;
			lim_q   <= lim_d;
			cmd_q   <= cmd_d;
			home_q  <= home_d;
			done_q  <= done_d;
			err_q   <= err_d;
		end
	end

	assign cmd_o      = cmd_q;
	assign home_pos_o = home_q;
	assign done_o     = done_q;
	assign busy_o     = cmd_q.run;
	assign err_o      = err_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	AST_DONE_STOPS: assert property (done_o |-> !cmd_o.run)
		else $error("axis still commanded after done");

	AST_LATCH_POS: assert property ($rose(done_o) |-> home_pos_o == $past(pos_i))
		else $error("home position not the counter at the edge");

	AST_DONE_HOLD: assert property (done_o && !trig_i |=> done_o)
		else $error("done dropped without a trigger");

	AST_M17_LOW: assert property (accept && method_i == shs_pkg::METH_NEG_LIM && !sw_q.neg
		|=> cmd_o.run && !cmd_o.fwd && cmd_o.speed == $past(speed1_i))
		else $error("method 17 low start not reverse first speed");

	AST_M18_HIGH: assert property (accept && method_i == shs_pkg::METH_POS_LIM && sw_q.pos
		|=> cmd_o.run && !cmd_o.fwd && cmd_o.speed == $past(speed2_i))
		else $error("method 18 high start not reverse second speed");

	AST_M20_LOW: assert property (accept && method_i == shs_pkg::METH_HOME_B && !sw_q.home
		|=> cmd_o.run && cmd_o.fwd && cmd_o.speed == $past(speed1_i))
		else $error("method 20 low start not forward first speed");

	AST_M22_HIGH: assert property (accept && method_i == shs_pkg::METH_HOME_D && sw_q.home
		|=> cmd_o.run && cmd_o.fwd && cmd_o.speed == $past(speed2_i))
		else $error("method 22 high start not forward second speed");

	AST_LIM_REV: assert property ($rose(lim_q) |-> cmd_o.run && !cmd_o.fwd
		&& cmd_o.speed == $past(speed1_i))
		else $error("limit did not reverse at first speed");

	AST_SYNC_AGREE: assert property (sw_q != $past(sw_q) |-> $past(sync2_q) == $past(sync3_q))
		else $error("switch level taken before stages agreed");

	AST_M19_HIGH: assert property (accept && method_i == shs_pkg::METH_HOME_A && sw_q.home
		|=> cmd_o.run && !cmd_o.fwd && cmd_o.speed == $past(speed2_i))
		else $error("method 19 high start not reverse second speed");

	// A run in progress must not take a new method
	AST_BUSY_IGNORE: assert property (moving && trig_i |=> meth_q == $past(meth_q))
		else $error("trigger accepted while moving");

	COV_M17_DONE: cover property (meth_q == shs_pkg::METH_NEG_LIM && $rose(done_o));
	COV_LIM_M24: cover property (meth_q == shs_pkg::METH_PLIM_B && lim_q && $rose(done_o));
	COV_M25_THREE: cover property (meth_q == shs_pkg::METH_PLIM_C && state_q == shs_pkg::ST_SEG2);
	COV_BAD_METH: cover property ($rose(err_o));
	COV_BUSY_TRIG: cover property (moving && trig_i);

endmodule // shs_homing

// ### verification/shs_axis_model.sv
// Purpose: behavioural axis with limit and home switches for the homing bench
// Assumes: the axis moves by the commanded speed every cycle while run is high
// Notes:   the home switch is a window the bench sets for each case
`timescale 1ns/10ps

module shs_axis_model (
	input  wire logic                      clk_i,
	input  wire shs_pkg::shs_cmd_t         cmd_i,
	input  wire logic                      load_i,
	input  wire logic [shs_pkg::POS_W-1:0] load_val_i,
	input  wire logic [shs_pkg::POS_W-1:0] hlo_i,
	input  wire logic [shs_pkg::POS_W-1:0] hhi_i,
	output logic      [shs_pkg::POS_W-1:0] pos_o,
	output shs_pkg::shs_sw_t               sw_o
);
	localparam logic [31:0] NEG_END   = 32'h000007D0;
	localparam logic [31:0] POS_START = 32'h00004650;

	always_ff @(posedge clk_i) begin
		if (load_i) begin
			pos_o <= load_val_i;
		end else if (cmd_i.run) begin
			pos_o <= cmd_i.fwd ? pos_o + 32'(cmd_i.speed) : pos_o - 32'(cmd_i.speed);
		end
	end

	// Pins follow position at once; the sequencer must synchronise them
	always_comb begin
		sw_o.neg  = pos_o < NEG_END;
		sw_o.pos  = pos_o > POS_START;
		sw_o.home = (pos_o >= hlo_i) && (pos_o <= hhi_i);
	end
endmodule // shs_axis_model

// ### verification/tb_top.sv
// Purpose: self-checking bench for the homing sequencer, methods 17 to 25
// Assumes: first speed 4 counts a cycle, second speed 1
// Notes:   latched position checked in a window; synchronising causes overshoot
`timescale 1ns/10ps

module tb_top;
	localparam logic [31:0] P0 = 32'h0;
	localparam logic [31:0] P1K5 = 32'h5DC;
	localparam logic [31:0] P2K = 32'h7D0;
	localparam logic [31:0] P5K = 32'h1388;
	localparam logic [31:0] P8K = 32'h1F40;
	localparam logic [31:0] P10K = 32'h2710;
	localparam logic [31:0] P11K = 32'h2AF8;
	localparam logic [31:0] P12K = 32'h2EE0;
	localparam logic [31:0] P14K = 32'h36B0;
	localparam logic [31:0] P15K = 32'h3A98;
	localparam logic [31:0] P18K = 32'h4650;
	localparam logic [31:0] P18K5 = 32'h4844;
	localparam logic [31:0] P30K = 32'h7530;
	localparam logic [31:0] P40K = 32'h9C40;

	// Segment codes {fwd, second speed}, first segment in the low bits
	typedef struct packed {
		logic [5:0]  meth;
		logic [31:0] start;
		logic [31:0] hlo;
		logic [31:0] hhi;
		logic [1:0]  n;
		logic [7:0]  seq;
		logic [31:0] hpos;
	} shs_row_t;

	logic              clk_i = 1'b0;
	logic              nrst_i;
	logic              trig_i;
	logic [5:0]        method_i;
	logic [15:0]       speed1_i;
	logic [15:0]       speed2_i;
	logic              load_i;
	logic [31:0]       load_val;
	logic [31:0]       hlo;
	logic [31:0]       hhi;
	logic [31:0]       pos;
	shs_pkg::shs_sw_t  sw;
	shs_pkg::shs_cmd_t cmd_o;
	logic [31:0]       home_pos_o;
	logic              done_o;
	logic              busy_o;
	logic              err_o;
	int                num_errors = 0;
	int                checked = 0;

	shs_row_t rows [21] = '{
		'{6'h11, P5K, P30K, P30K, 2'h2, 8'h0C, P2K}, '{6'h11, P1K5, P30K, P30K, 2'h1, 8'h03, P2K},
		'{6'h12, P15K, P30K, P30K, 2'h2, 8'h06, P18K}, '{6'h12, P18K5, P30K, P30K, 2'h1, 8'h01, P18K},
		'{6'h13, P8K, P10K, P40K, 2'h2, 8'h06, P10K}, '{6'h13, P12K, P10K, P40K, 2'h1, 8'h01, P10K},
		'{6'h14, P8K, P10K, P40K, 2'h1, 8'h02, P10K}, '{6'h14, P12K, P10K, P40K, 2'h2, 8'h09, P10K},
		'{6'h15, P12K, P0, P10K, 2'h2, 8'h0C, P10K}, '{6'h15, P8K, P0, P10K, 2'h1, 8'h03, P10K},
		'{6'h16, P8K, P0, P10K, 2'h2, 8'h03, P10K}, '{6'h16, P12K, P0, P10K, 2'h1, 8'h00, P10K},
		'{6'h17, P8K, P10K, P12K, 2'h2, 8'h06, P10K}, '{6'h17, P11K, P10K, P12K, 2'h1, 8'h01, P10K},
		'{6'h18, P8K, P10K, P12K, 2'h1, 8'h02, P10K}, '{6'h18, P11K, P10K, P12K, 2'h2, 8'h0D, P10K},
		'{6'h19, P8K, P10K, P12K, 2'h3, 8'h1E, P12K}, '{6'h19, P11K, P10K, P12K, 2'h2, 8'h07, P12K},
		'{6'h17, P14K, P10K, P12K, 2'h3, 8'h12, P10K}, '{6'h18, P14K, P10K, P12K, 2'h3, 8'h32, P10K},
		'{6'h19, P14K, P10K, P12K, 2'h2, 8'h02, P12K}};

	always #5 clk_i = ~clk_i;

	shs_homing shs_homing_inst (
		.clk_i(clk_i), .nrst_i(nrst_i), .trig_i(trig_i), .method_i(method_i),
		.speed1_i(speed1_i), .speed2_i(speed2_i), .pos_i(pos), .sw_pin_i(sw),
		.cmd_o(cmd_o), .home_pos_o(home_pos_o), .done_o(done_o), .busy_o(busy_o),
		.err_o(err_o));

	shs_axis_model shs_axis_model_inst (
		.clk_i(clk_i), .cmd_i(cmd_o), .load_i(load_i), .load_val_i(load_val),
		.hlo_i(hlo), .hhi_i(hhi), .pos_o(pos), .sw_o(sw));

	task chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task results;
		$display("Checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask

	// Settle time covers the synchroniser and its filter
	task place(input logic [31:0] p, input logic [31:0] lo, input logic [31:0] hi);
		load_i = 1'b1;
		load_val = p;
		hlo = lo;
		hhi = hi;
		cyc(1);
		load_i = 1'b0;
		cyc(6);
	endtask

	task pulse(input logic [5:0] m);
		method_i = m;
		trig_i = 1'b1;
		cyc(1);
		trig_i = 1'b0;
	endtask

	task run_row(input shs_row_t r);
		logic [7:0]        got;
		int                n;
		int                k;
		logic [1:0]        code;
		shs_pkg::shs_cmd_t last;
		got = 8'h00;
		n = 0;
		last = '0;
		place(r.start, r.hlo, r.hhi);
		pulse(r.meth);
		for (k = 0; k < 20000 && done_o !== 1'b1; k++) begin
			if (cmd_o.run === 1'b1 && cmd_o !== last) begin
				code = {cmd_o.fwd, cmd_o.speed === speed2_i};
				chk(cmd_o.speed === (code[0] ? speed2_i : speed1_i), "speed value");
				got = got | (8'(code) << (2 * n));
				n++;
				last = cmd_o;
			end
			cyc(1);
		end
		if (k == 20000) begin
			chk(1'b0, "timeout waiting for done");
			results();
		end
		chk(n == int'(r.n) && got === r.seq, "segment order");
		chk(home_pos_o >= r.hpos - 40 && home_pos_o <= r.hpos + 40, "home position");
		cyc(3);
		chk(cmd_o === '0 && busy_o === 1'b0 && err_o === 1'b0 && done_o === 1'b1, "stop");
	endtask

	initial begin
		nrst_i = 1'b0;
		trig_i = 1'b0;
		method_i = 6'h11;
		speed1_i = 16'h0004;
		speed2_i = 16'h0001;
		load_i = 1'b1;
		load_val = P5K;
		hlo = P30K;
		hhi = P30K;
		cyc(20);
		chk(cmd_o === '0 && done_o === 1'b0 && busy_o === 1'b0 && home_pos_o === '0, "reset");
		nrst_i = 1'b1;
		cyc(6);
		for (int i = 0; i < 21; i++) begin
			run_row(rows[i]);
		end
		// Unsupported methods just outside both ends of the range
		pulse(6'h10);
		cyc(1);
		chk(err_o === 1'b1 && busy_o === 1'b0 && done_o === 1'b0, "low method");
		pulse(6'h1A);
		cyc(1);
		chk(err_o === 1'b1 && busy_o === 1'b0, "high method");
		place(P12K, P10K, P40K);
		pulse(6'h13);
		cyc(10);
		chk(cmd_o === {1'b1, 1'b0, speed2_i} && err_o === 1'b0, "reverse slow start");
		pulse(6'h11);
		cyc(3);
		chk(cmd_o === {1'b1, 1'b0, speed2_i} && busy_o === 1'b1 && done_o === 1'b0, "busy trig");
		speed2_i = 16'h0002;
		cyc(3);
		chk(cmd_o.speed === 16'h0002, "speed follows input");
		nrst_i = 1'b0;
		cyc(1);
		chk(cmd_o === '0 && busy_o === 1'b0 && done_o === 1'b0 && home_pos_o === '0, "reset");
		nrst_i = 1'b1;
		speed2_i = 16'h0001;
		cyc(6);
		chk(cmd_o === '0 && done_o === 1'b0 && err_o === 1'b0, "quiet after release");
		run_row(rows[0]);
		results();
	end
endmodule // tb_top
